// >>> fcor_pkg.sv
// Notes on behaviour
// R01: ratio bit 7 read-only; bits 6:0 readable always, only first write after reset lands.
// R02: ratio-loaded flag cleared by reset, set by first ratio write, any data.
// R03: program and erase refused while ratio-loaded flag is zero, allowed once set.
// R04: ratio bit 6 picks timing source: bus clock, or bus clock divided by 8.
// R05: timing clock is selected source divided by ratio field bits 5:0 plus one.
// R06: software keeps the timing clock between 150 kHz and 200 kHz.
// R07: each timing pulse is one timing clock cycle; operations use whole pulses.
// R08: suggested settings: 20 MHz 1/12, 10 MHz 0/49, 4 MHz 0/19.
// R09: options loaded from stored byte during reset; changed only by reprogram then reset.
// R10: backdoor key enable at zero means the key never releases security.
// R11: key comparison writes accepted from firmware only, never from background debug.
// R12: eight matching key bytes in ascending order release security until next reset.
// R13: options bit 6 set disables vector redirection, clear enables it.
// R14: security code 1:0 means unsecured; every other code means secure.
// R15: while secure, memory accesses from unsecured sources are blocked.
// R16: security code becomes 1:0 after key match or full blank check.
// R17: blocked write discarded, blocked read returns all zeros.
// R18: options bits 5:2 read as zero, writes to them do nothing.
//
// constants, state record and helpers for the flash clock and option registers
// assumes a single 250 MHz bus clock and an APB master with 32-bit data
package fcor_pkg;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_RATIO = 12'h000;
    localparam logic [11:0] OFF_OPTIONS = 12'h004;
    localparam logic [11:0] OFF_KEY_CTRL = 12'h008;
    localparam logic [11:0] OFF_KEY_DATA = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam int RATIO_LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
    localparam int OPT_NORED_BIT = 6;
    localparam logic [7:0] OPT_IMPL_MASK = 8'hc3;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] RATIO_RESET = 8'h00;
    localparam int ST_SECURE = 0;
    localparam int ST_LOADED = 1;
    localparam int ST_PE_ALLOWED = 2;
    localparam int ST_UNLOCKED = 3;
    localparam int ST_PE_BUSY = 4;
    localparam int ST_IN_WINDOW = 5;
    localparam int ST_KEY_MODE = 6;
    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [3:0] KEY_BYTES = 4'h8;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PULSE_MIN_PS = 5000000;
    localparam int PULSE_MAX_PS = 6700000;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_PS / CLK_PERIOD_PS;
    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {FCOR_PE_IDLE = 2'h0, FCOR_PE_ALIGN = 2'h1, FCOR_PE_PULSE = 2'h3} fcor_pe_t;
    typedef struct packed {
        logic [7:0] ratio;
        logic [7:0] opts;
        logic [2:0] pre;
        logic [5:0] div;
        logic tick;
        fcor_pe_t pe;
        logic [7:0] left;
        logic pe_reject;
        logic pe_done;
        logic key_mode;
        logic [3:0] key_idx;
        logic key_match;
        logic unlocked;
        logic [31:0] prdata;
        logic [7:0] mem_rdata;
        logic [9:0] gap;
        logic gap_valid;
    } fcor_state_t;
    // timing period in bus cycles for a ratio value
    function automatic logic [9:0] fcor_period(input logic [7:0] r);
        logic [9:0] base;
        base = {4'h0, r[5:0]} + 10'h001;
        return r[PRESCALE_BIT] ? {base[6:0], 3'h0} : base;
    endfunction : fcor_period
    function automatic logic fcor_is_secure(input logic [7:0] o);
        return o[1:0] != SEC_UNSECURED;
    endfunction : fcor_is_secure
endpackage : fcor_pkg

// >>> fcor_top.sv
// flash clock-ratio register, options register, timing clock and security gate
// assumes APB master on CLOCK, stored options and key sampled on the same clock
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module fcor_top import fcor_pkg::*; (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // current bus master is background debug
    input wire logic DEBUG_ACCESS,
    // nonvolatile copies and blank check result
    input wire logic [7:0] STORED_OPTIONS,
    input wire logic [63:0] STORED_KEY,
    input wire logic BLANK_CHECK_OK,
    // program and erase timing
    input wire logic PE_START,
    input wire logic [7:0] PE_PULSES,
    output logic PE_ACTIVE,
    output logic PE_DONE,
    output logic PE_REJECT,
    output logic TIMING_TICK,
    // option outputs
    output logic REDIRECT_DISABLE,
    output logic SECURE,
    // memory access gate
    input wire logic MEM_SRC_SECURE,
    input wire logic MEM_WR_REQ,
    input wire logic [7:0] MEM_RDATA_IN,
    output logic MEM_WR_EN,
    output logic [7:0] MEM_RDATA
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    fcor_state_t st_reg;
    fcor_state_t st_next;
    logic setup_phase;
    logic wr_access;
    logic addr_hit;
    logic loaded;
    logic secure;
    logic grant;
    logic src_en;
    logic key_wr;
    logic [7:0] status;
    logic [7:0] key_byte;

    assign loaded = st_reg.ratio[RATIO_LOADED_BIT];
    assign secure = fcor_is_secure(st_reg.opts);
    // R15 source gate
    assign grant = !secure || MEM_SRC_SECURE;
    assign setup_phase = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign addr_hit = (PADDR == OFF_RATIO) || (PADDR == OFF_OPTIONS) || (PADDR == OFF_KEY_CTRL)
        || (PADDR == OFF_KEY_DATA) || (PADDR == OFF_STATUS);
    // R11 debug writes never reach the comparator
    assign key_wr = wr_access && (PADDR == OFF_KEY_DATA) && st_reg.key_mode && !DEBUG_ACCESS;
    assign key_byte = STORED_KEY[{st_reg.key_idx[2:0], 3'h0} +: 8];
    // R04 eighth prescale select
    assign src_en = !st_reg.ratio[PRESCALE_BIT] || (st_reg.pre == PRESCALE_LAST);

    always_comb begin
        status = 8'h00;
        status[ST_SECURE] = secure;
        status[ST_LOADED] = loaded;
        status[ST_PE_ALLOWED] = loaded;
        status[ST_UNLOCKED] = st_reg.unlocked;
        status[ST_PE_BUSY] = st_reg.pe != FCOR_PE_IDLE;
        status[ST_IN_WINDOW] = (int'(fcor_period(st_reg.ratio)) >= PULSE_MIN_CYC)
            && (int'(fcor_period(st_reg.ratio)) <= PULSE_MAX_CYC);
        status[ST_KEY_MODE] = st_reg.key_mode;
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        st_next.pe_reject = 1'b0;
        st_next.pe_done = 1'b0;

        // register reads are captured in setup, presented in access
        if (setup_phase) begin
            case (PADDR)
                OFF_RATIO: st_next.prdata = {24'h0, st_reg.ratio};
                // R18 unimplemented option bits read zero
                OFF_OPTIONS: st_next.prdata = {24'h0, st_reg.opts & OPT_IMPL_MASK};
                OFF_KEY_CTRL: st_next.prdata = {31'h0, st_reg.key_mode};
                OFF_STATUS: st_next.prdata = {24'h0, status};
                default: st_next.prdata = 32'h0;
            endcase
        end

        // R01 only the first write lands
        // R02 loaded flag set whatever the data
        if (wr_access && (PADDR == OFF_RATIO) && !loaded) begin
            st_next.ratio = {1'b1, PWDATA[6:0]};
            st_next.pre = 3'h0;
            st_next.div = 6'h0;
        end

        // R05 divider runs only once the ratio is known
        if (loaded) begin
            st_next.pre = st_reg.pre + 3'h1;
            if (src_en) begin
                if (st_reg.div == st_reg.ratio[5:0]) begin
                    st_next.div = 6'h0;
                    st_next.tick = 1'b1;
                end else begin
                    st_next.div = st_reg.div + 6'h1;
                end
            end
        end

        // gap measure between ticks
        if (st_reg.tick) begin
            st_next.gap = 10'h001;
            st_next.gap_valid = 1'b1;
        end else if (loaded) begin
            st_next.gap = st_reg.gap + 10'h001;
        end

        // R03 program and erase gated by loaded flag
        // R07 pulses span whole timing periods
        case (st_reg.pe)
            FCOR_PE_IDLE: begin
                if (PE_START) begin
                    if (!loaded) begin
                        st_next.pe_reject = 1'b1;
                    end else begin
                        st_next.left = (PE_PULSES == 8'h00) ? 8'h01 : PE_PULSES;
                        st_next.pe = FCOR_PE_ALIGN;
                    end
                end
            end
            FCOR_PE_ALIGN: begin
                st_next.pe_reject = PE_START;
                if (st_reg.tick) begin
                    st_next.pe = FCOR_PE_PULSE;
                end
            end
            FCOR_PE_PULSE: begin
                st_next.pe_reject = PE_START;
                if (st_reg.tick) begin
                    if (st_reg.left == 8'h01) begin
                        st_next.pe = FCOR_PE_IDLE;
                        st_next.pe_done = 1'b1;
                    end else begin
                        st_next.left = st_reg.left - 8'h01;
                    end
                end
            end
            default: st_next.pe = FCOR_PE_IDLE;
        endcase

        // key comparison mode; leaving it judges the sequence
        if (wr_access && (PADDR == OFF_KEY_CTRL) && !DEBUG_ACCESS) begin
            st_next.key_mode = PWDATA[0];
            if (PWDATA[0] && !st_reg.key_mode) begin
                st_next.key_idx = 4'h0;
                st_next.key_match = 1'b1;
            end
            // R10 key release needs the enable
            // R12 eight bytes, ascending, all matching
            if (!PWDATA[0] && st_reg.key_mode && st_reg.opts[OPT_BACKDOOR_KEY_ENABLE_BIT]
                && st_reg.key_match && (st_reg.key_idx == KEY_BYTES)) begin
                st_next.unlocked = 1'b1;
            end
        end
        if (key_wr) begin
            if (st_reg.key_idx == KEY_BYTES) begin
                st_next.key_match = 1'b0;
            end else begin
                st_next.key_idx = st_reg.key_idx + 4'h1;
                if (PWDATA[7:0] != key_byte) begin
                    st_next.key_match = 1'b0;
                end
            end
        end

        // R16 key match or blank check unsecures
        if (st_next.unlocked || BLANK_CHECK_OK) begin
            st_next.opts[1:0] = SEC_UNSECURED;
        end

        // R17 blocked read returns zero
        st_next.mem_rdata = grant ? MEM_RDATA_IN : 8'h00;

        // R09 options follow the stored byte during reset
        if (!NRST) begin
            st_next = '0;
            st_next.ratio = RATIO_RESET;
            st_next.opts = STORED_OPTIONS & OPT_IMPL_MASK;
            st_next.pe = FCOR_PE_IDLE;
        end
    end

    always_ff @(posedge CLOCK) begin
        st_reg <= st_next;
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign PRDATA = st_reg.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit;
    assign PE_ACTIVE = st_reg.pe == FCOR_PE_PULSE;
    assign PE_DONE = st_reg.pe_done;
    assign PE_REJECT = st_reg.pe_reject;
    assign TIMING_TICK = st_reg.tick;
    // R13 redirect disable bit
    assign REDIRECT_DISABLE = st_reg.opts[OPT_NORED_BIT];
    // R14 only code 1:0 is unsecured
    assign SECURE = secure;
    // R17 blocked write discarded
    assign MEM_WR_EN = MEM_WR_REQ && grant;
    assign MEM_RDATA = st_reg.mem_rdata;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    AST_RATIO_WRITE_ONCE: assert property ( // R01
        $past(loaded) && $past(NRST) |-> st_reg.ratio == $past(st_reg.ratio))
        else $error("ratio changed after first write");

    AST_LOADED_ON_FIRST_WRITE: assert property ( // R02
        wr_access && (PADDR == OFF_RATIO) && !loaded
        |=> loaded && st_reg.ratio[6:0] == $past(PWDATA[6:0]))
        else $error("first ratio write did not load");

    AST_PE_REFUSED: assert property ( // R03
        PE_START && !loaded && st_reg.pe == FCOR_PE_IDLE |=> PE_REJECT && !PE_ACTIVE ##1 !PE_ACTIVE)
        else $error("program or erase not refused before ratio load");

    AST_TICK_PERIOD: assert property ( // R05
        st_reg.tick && st_reg.gap_valid |-> st_reg.gap == fcor_period(st_reg.ratio))
        else $error("timing tick spacing wrong");

    AST_PULSE_ALIGNED: assert property ( // R07
        ($rose(PE_ACTIVE) || $fell(PE_ACTIVE)) |-> $past(st_reg.tick))
        else $error("timing pulse edge off tick");

    AST_NO_KEY_RELEASE: assert property ( // R10
        !st_reg.opts[OPT_BACKDOOR_KEY_ENABLE_BIT] |-> !st_reg.unlocked)
        else $error("key released with enable clear");

    AST_DEBUG_KEY_IGNORED: assert property ( // R11
        wr_access && DEBUG_ACCESS && (PADDR == OFF_KEY_DATA)
        |=> st_reg.key_idx == $past(st_reg.key_idx) && st_reg.key_match == $past(st_reg.key_match))
        else $error("debug key write was taken");

    AST_UNLOCK_SECURES_OFF: assert property ( // R16
        $rose(st_reg.unlocked) |-> !SECURE ##1 !SECURE)
        else $error("key match left device secure");

    // independent of the helper: only high bit set, low bit clear opens the part
    AST_SECURE_CODE: assert property ( // R14
        SECURE == !(st_reg.opts[1] && !st_reg.opts[0]))
        else $error("secure output disagrees with code");

    AST_BLOCKED_READ_ZERO: assert property ( // R17
        SECURE && !MEM_SRC_SECURE |=> MEM_RDATA == 8'h00)
        else $error("blocked read returned data");

    AST_RESERVED_ZERO: assert property ( // R18
        PSEL && PENABLE && !PWRITE && (PADDR == OFF_OPTIONS)
        |-> PRDATA[5:2] == 4'h0 && PRDATA[31:8] == 24'h000000)
        else $error("reserved option bits not zero");

endmodule : fcor_top

// >>> fcor_top_test.sv
// self-checking bench for the flash clock-ratio and options register block
// assumes fcor_pkg compiled first; bench is the only APB master and drives all inputs
`timescale 1ns/1ps
module fcor_top_test import fcor_pkg::*;;
    typedef struct packed {
        logic [7:0] stored;
        logic [7:0] readback;
        logic secure;
        logic redirect;
    } fcor_row_t;
    `define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
        $display("mismatch %s expected %h seen %h", what, exp, got); end end
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, debug_access = 1'b0;
    logic [7:0] stored_options = 8'h00;
    logic [63:0] stored_key = 64'h8877665544332211;
    logic blank_check_ok = 1'b0;
    logic pe_start = 1'b0;
    logic [7:0] pe_pulses = 8'h00;
    logic pe_active, pe_done, pe_reject, timing_tick, redirect_disable, secure;
    logic mem_src_secure = 1'b0;
    logic mem_wr_req = 1'b0;
    logic [7:0] mem_rdata_in = 8'h00;
    logic mem_wr_en;
    logic [7:0] mem_rdata;
    logic [31:0] rdata;
    logic rerr;
    int mismatches = 0;
    int samples_checked = 0;
    int cnt, rej, per;
    fcor_row_t rows [4] = '{'{8'h00, 8'h00, 1'b1, 1'b0}, '{8'h41, 8'h41, 1'b1, 1'b1},
                            '{8'hbe, 8'h82, 1'b0, 1'b0}, '{8'hff, 8'hc3, 1'b1, 1'b1}};

    always #2 clock = ~clock;

    fcor_top i_dut (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .DEBUG_ACCESS(debug_access), .STORED_OPTIONS(stored_options), .STORED_KEY(stored_key),
        .BLANK_CHECK_OK(blank_check_ok), .PE_START(pe_start), .PE_PULSES(pe_pulses),
        .PE_ACTIVE(pe_active), .PE_DONE(pe_done), .PE_REJECT(pe_reject), .TIMING_TICK(timing_tick),
        .REDIRECT_DISABLE(redirect_disable), .SECURE(secure), .MEM_SRC_SECURE(mem_src_secure),
        .MEM_WR_REQ(mem_wr_req), .MEM_RDATA_IN(mem_rdata_in), .MEM_WR_EN(mem_wr_en),
        .MEM_RDATA(mem_rdata));

    // ---------------------------------------------------------------
    // bus and housekeeping tasks
    // ---------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        if (n >= 64) mismatches++;
    endtask : apb

    task automatic do_reset(input logic [7:0] opts);
        @(posedge clock);
        nrst <= 1'b0;
        stored_options <= opts;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
    endtask : do_reset

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cycles

    // edges between two ticks; the first tick after a load is only roughly placed
    task automatic tick_period(output int p);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (timing_tick !== 1'b1 && n < 4000);
        p = 0;
        do begin
            @(posedge clock);
            p++;
        end while (timing_tick !== 1'b1 && p < 4000);
    endtask : tick_period

    task automatic key_try(input logic [63:0] key, input logic dbg);
        @(posedge clock);
        debug_access <= dbg;
        apb(1'b1, OFF_KEY_CTRL, 32'h00000001);
        for (int i = 0; i < 8; i++) apb(1'b1, OFF_KEY_DATA, {24'h000000, key[8*i +: 8]});
        apb(1'b1, OFF_KEY_CTRL, 32'h00000000);
        debug_access <= 1'b0;
        wait_cycles(4);
    endtask : key_try

    task automatic test_end(input string name);
        $display("test %s finished, %0d mismatches so far", name, mismatches);
    endtask : test_end

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        foreach (rows[i]) begin
            do_reset(rows[i].stored);
            apb(1'b1, OFF_OPTIONS, 32'h000000ff);
            apb(1'b0, OFF_OPTIONS, 32'h00000000);
            `CHK("options", {24'h000000, rows[i].readback}, rdata)
            `CHK("secure", rows[i].secure, secure)
            `CHK("redirect", rows[i].redirect, redirect_disable)
        end
        test_end("options table");
        for (int k = 0; k < 2; k++) begin
            do_reset(8'h00);
            apb(1'b0, OFF_RATIO, 32'h00000000);
            `CHK("ratio reset", 32'h00000000, rdata)
            @(posedge clock);
            pe_start <= 1'b1;
            pe_pulses <= 8'h01;
            @(posedge clock);
            pe_start <= 1'b0;
            // look once the refusal pulse has settled, not at its launching edge
            #1;
            `CHK("early reject", 1'b1, pe_reject)
            apb(1'b1, OFF_RATIO, k ? 32'h00000003 : 32'h0000004c);
            apb(1'b1, OFF_RATIO, 32'h00000005);
            apb(1'b0, OFF_RATIO, 32'h00000000);
            `CHK("ratio", k ? 32'h00000083 : 32'h000000cc, rdata)
            tick_period(per);
            `CHK("period", k ? 4 : 104, per)
        end
        // with P = 4 run three pulses, a second start mid-run must be refused
        @(posedge clock);
        pe_start <= 1'b1;
        pe_pulses <= 8'h03;
        cnt = 0;
        rej = 0;
        for (int n = 0; n < 200 && pe_done !== 1'b1; n++) begin
            @(posedge clock);
            pe_start <= (cnt == 2);
            if (pe_active === 1'b1) cnt++;
            if (pe_reject === 1'b1) rej++;
        end
        // run must end with its done pulse
        `CHK("pe done", 1'b1, pe_done)
        `CHK("active cycles", 12, cnt)
        `CHK("busy reject", 1, rej)
        test_end("ratio and timing");
        do_reset(8'h80);
        @(posedge clock);
        mem_src_secure <= 1'b0;
        mem_wr_req <= 1'b1;
        mem_rdata_in <= 8'ha5;
        wait_cycles(2);
        `CHK("blocked write", 1'b0, mem_wr_en)
        `CHK("blocked read", 8'h00, mem_rdata)
        key_try(stored_key, 1'b1);
        `CHK("debug key", 1'b1, secure)
        key_try(stored_key ^ 64'h0100000000000000, 1'b0);
        `CHK("wrong key", 1'b1, secure)
        key_try(stored_key, 1'b0);
        `CHK("good key", 1'b0, secure)
        apb(1'b0, OFF_OPTIONS, 32'h00000000);
        `CHK("code after key", 32'h00000082, rdata)
        `CHK("open write", 1'b1, mem_wr_en)
        `CHK("open read", 8'ha5, mem_rdata)
        test_end("key and gate");
        do_reset(8'h00);
        key_try(stored_key, 1'b0);
        `CHK("key disabled", 1'b1, secure)
        @(posedge clock);
        blank_check_ok <= 1'b1;
        @(posedge clock);
        blank_check_ok <= 1'b0;
        wait_cycles(3);
        `CHK("blank check", 1'b0, secure)
        apb(1'b0, 12'h0f0, 32'h00000000);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h00000000, rdata)
        test_end("blank check and unmapped");
        report_and_stop();
    end

    // hang guard: whole run needs a few hundred cycles
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule : fcor_top_test
